// *** hw/amp_ctrl_pkg.sv ***
// Purpose: shared constants and types for the differential amplifier control block
// Assumes: one 10 MHz clock, AXI4-Lite register access, 32-bit data
// Notes: register offsets are byte addresses
// Overview of operation
// - bit 7 of each channel register switches that amplifier on or off.
// - clearing the enable during a conversion on that channel takes effect when it ends.
// - bit 6 shorts the amplifier inputs together while set.
// - bits 5:4 select gain 5, 10, 20 or 40 for codes 00, 01, 10, 11.
// - bits 1:0 pick the clock/8 sync or power stage event 0, 1 or 2.
// - a power stage conversion starts only on the selected event; a clock/8 conversion starts at once on request.
// - these registers only configure; the start request comes from the converter side.
// - the result goes to the one result word, its high byte holding the upper bits.
// - an enabled amplifier amplifies on every sync event, converter running or not.
// - a clock/8 conversion takes 13 cycles if requested while the divided clock is low, else 14.
package amp_ctrl_pkg;
  localparam logic [7:0] AMP0_OFFSET = 8'h00;
  localparam logic [7:0] AMP1_OFFSET = 8'h04;
  localparam logic [7:0] RESULT_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam int ON_BIT = 7;
  localparam int SHORT_BIT = 6;
  localparam int GAIN_HI = 5;
  localparam int GAIN_LO = 4;
  localparam int TRIG_HI = 1;
  localparam int TRIG_LO = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hF3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] TRIG_DIV8 = 2'h0;
  localparam int DIV_RATIO = 8;
  localparam logic [2:0] DIV_HALF = 3'h4;
  localparam logic [3:0] CONV_CYC_LOW = 4'hD;
  localparam logic [3:0] CONV_CYC_HIGH = 4'hE;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic on;
    logic inputShort;
    logic [1:0] gain;
    logic [1:0] trigSel;
  } amp_cfg_s;
  typedef enum {CONV_IDLE, CONV_WAIT_TRIG, CONV_RUN} conv_state_e;
endpackage

// *** hw/amp_channel.sv ***
// Purpose: one amplifier channel: enable hold-off, trigger pick, conversion timing
// Assumes: inputs synchronous to clock
// Notes: analog conversion is modelled as a cycle count; the result is sampled at its end
`timescale 1ns/10ps
`default_nettype none
module amp_channel
  import amp_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] ctrlReg,
  input wire logic [2:0] psEvent,
  input wire logic divTick,
  input wire logic divLevel,
  input wire logic startReq,
  input wire logic [9:0] sampleIn,
  output amp_cfg_s cfg,
  output logic ampPulse,
  output logic busy,
  output logic done,
  output logic [9:0] result
);
  conv_state_e state_q;
  logic [3:0] count_q;
  logic onHeld_q;
  logic trig;
  logic selOn;

  // selected sync event
  always_comb begin
    case (ctrlReg[TRIG_HI:TRIG_LO])
      TRIG_DIV8: trig = divTick;
      2'h1: trig = psEvent[0];
      2'h2: trig = psEvent[1];
      2'h3: trig = psEvent[2];
      default: trig = 1'b0;
    endcase
  end
  // the held copy counts only mid-conversion, so an idle disable bites at once
  assign selOn = ctrlReg[ON_BIT] | (onHeld_q && state_q != CONV_IDLE);

  // disable waits while busy so the sample is not cut short
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      onHeld_q <= 1'b0;
    end else if (state_q == CONV_IDLE) begin
      onHeld_q <= ctrlReg[ON_BIT];
    end else if (ctrlReg[ON_BIT]) begin
      onHeld_q <= 1'b1;
    end
  end

  // amplification pulse on every selected sync event while selOn is set, independent of conversion
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ampPulse <= 1'b0;
      cfg <= '0;
    end else begin
      ampPulse <= selOn & trig;
      cfg <= '{on: selOn, inputShort: ctrlReg[SHORT_BIT],
               gain: ctrlReg[GAIN_HI:GAIN_LO], trigSel: ctrlReg[TRIG_HI:TRIG_LO]};
    end
  end

  // conversion sequencer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CONV_IDLE;
      count_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      case (state_q)
        CONV_IDLE: begin
          if (startReq && selOn) begin
            busy <= 1'b1;
            if (ctrlReg[TRIG_HI:TRIG_LO] == TRIG_DIV8) begin
              state_q <= CONV_RUN;
              // divided clock high costs one extra sync cycle
              count_q <= divLevel ? CONV_CYC_HIGH - 4'h1 : CONV_CYC_LOW - 4'h1;
            end else begin
              state_q <= CONV_WAIT_TRIG;
            end
          end
        end
        CONV_WAIT_TRIG: begin
          if (trig) begin
            state_q <= CONV_RUN;
            count_q <= CONV_CYC_LOW - 4'h1;
          end
        end
        CONV_RUN: begin
          if (count_q == 4'h0) begin
            state_q <= CONV_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            result <= sampleIn;
          end else begin
            count_q <= count_q - 4'h1;
          end
        end
        default: state_q <= CONV_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hw/amp_ctrl.sv ***
// Purpose: AXI4-Lite register front end and clock/8 divider for two amplifier channels;
//   hold-off and conversion timing of each channel sit in its own instance
// Assumes: one clock, inputs synchronous, one write and one read outstanding at a time;
//   the master keeps each valid up until its own ready is seen
// Notes: result word holds high byte in 15:8 and low byte in 7:0, right adjusted;
//   the status word shows busy and effective enable of both channels, read only
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module amp_ctrl
  import amp_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  // write address, write data and write response
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and read data
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // far side and channel outputs
  input wire logic [2:0] power_stage_async_event,
  input wire logic [1:0] start_conv,
  input wire logic [9:0] sample_in,
  output amp_cfg_s amp0_cfg,
  output amp_cfg_s amp1_cfg,
  output logic [1:0] amp_pulse,
  output logic conv_clock_div8,
  output logic [1:0] conv_done
);
  // register file and divider
  logic [7:0] ctrl_q [2];
  logic [2:0] div_q;
  logic divTick;
  // write capture; address and data may arrive on different edges
  logic [7:0] awAddr_q;
  logic awHeld_q;
  logic wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  // per-channel results
  logic [1:0] busyCh;
  logic [1:0] doneCh;
  logic [9:0] resCh [2];
  logic [9:0] lastResult_q;
  amp_cfg_s cfgCh [2];
  logic [1:0] pulseCh;
  // read words built ahead of the read mux
  logic [31:0] resultWord;
  logic [31:0] statusWord;

  // free-running divide by eight
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      conv_clock_div8 <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      conv_clock_div8 <= (div_q + 3'h1) >= DIV_HALF;
    end
  end
  // the tick marks the last phase of each eight-cycle round
  assign divTick = (div_q == 3'(DIV_RATIO - 1));

  // channels
  // both share one divider, so their clock/8 phases always agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      amp_channel u_ch (
        .clock(clock),
        .reset_n(reset_n),
        .ctrlReg(ctrl_q[g]),
        .psEvent(power_stage_async_event),
        .divTick(divTick),
        .divLevel(conv_clock_div8),
        .startReq(start_conv[g]),
        .sampleIn(sample_in),
        .cfg(cfgCh[g]),
        .ampPulse(pulseCh[g]),
        .busy(busyCh[g]),
        .done(doneCh[g]),
        .result(resCh[g])
      );
    end
  endgenerate

  // outputs straight from channel flops, re-registered to keep one flop to pin
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      amp0_cfg <= '0;
      amp1_cfg <= '0;
      amp_pulse <= '0;
      conv_done <= '0;
      lastResult_q <= '0;
    end else begin
      amp0_cfg <= cfgCh[0];
      amp1_cfg <= cfgCh[1];
      amp_pulse <= pulseCh;
      conv_done <= doneCh;
      // channel 1 wins when both finish in one cycle
      if (doneCh[1]) begin
        lastResult_q <= resCh[1];
      end else if (doneCh[0]) begin
        lastResult_q <= resCh[0];
      end
    end
  end

  // write address and data accepted in either order
  // the held flags keep a second take out until the write fires; the next doWrite waits for the response to go
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // write response; doWrite cannot fire while a response still stands
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        // read-only words take writes silently; holes answer with an error
        if (awAddr_q == AMP0_OFFSET || awAddr_q == AMP1_OFFSET ||
            awAddr_q == RESULT_OFFSET || awAddr_q == STATUS_OFFSET) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
    end
  end

  // control registers; only byte lane 0 carries the 8-bit register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q[0] <= CTRL_RESET;
      ctrl_q[1] <= CTRL_RESET;
    end else if (doWrite && wStrb_q[0]) begin
      // software is expected to clear the trigger select with the enable
      if (awAddr_q == AMP0_OFFSET || awAddr_q == AMP1_OFFSET) begin
        ctrl_q[awAddr_q[2]] <= wData_q[7:0] & CTRL_WMASK;
      end
    end
  end

  // result and status words, kept apart from the read mux
  assign resultWord = {16'h0000, 6'h00, lastResult_q[9:8], lastResult_q[7:0]};
  assign statusWord = {28'h0000000, cfgCh[1].on, cfgCh[0].on, busyCh};

  // read channel, one cycle after the address is taken
  // arready stays low while data stand, so one read is under way at a time
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          AMP0_OFFSET: s_axi_rdata <= {24'h000000, ctrl_q[0]};
          AMP1_OFFSET: s_axi_rdata <= {24'h000000, ctrl_q[1]};
          RESULT_OFFSET: s_axi_rdata <= resultWord;
          STATUS_OFFSET: s_axi_rdata <= statusWord;
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** test/conv_side_model.sv ***
// Purpose: converter sequencer and power stage event source beside the block
// Assumes: fire and req come from the bench for one cycle each
// Notes: outputs are registered, so each request reaches the block one cycle late
`timescale 1ns/10ps
`default_nettype none
module conv_side_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] fire,
  input wire logic [1:0] req,
  output logic [2:0] psEvent,
  output logic [1:0] startReq
);
  // single-cycle pulses, as the power stages and sequencer emit them
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      psEvent <= 3'h0;
      startReq <= 2'h0;
    end else begin
      psEvent <= fire;
      startReq <= req;
    end
  end
endmodule
`default_nettype wire

// *** test/amp_ctrl_properties.sv ***
// Purpose: timing relations at the ports of the amplifier register block
// Assumes: one clock domain, reset_n async active low
// Notes: attached by the bind at the foot
`timescale 1ns/10ps
`default_nettype none
module amp_ctrl_properties
  import amp_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] power_stage_async_event,
  input wire amp_cfg_s amp0_cfg,
  input wire amp_cfg_s amp1_cfg,
  input wire logic [1:0] amp_pulse,
  input wire logic conv_clock_div8,
  input wire logic [1:0] conv_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_div_duty;
    $rose(conv_clock_div8) |-> conv_clock_div8[*4] ##1 !conv_clock_div8;
  endproperty
  a_div_duty: assert property (p_div_duty) else $error("divided clock not 4 high of 8");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
  property p_wr_answer;
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data missing");
  // enable must survive until the conversion it covers has ended
  property p_hold_on;
    conv_done[0] |-> $past(amp0_cfg.on, 2);
  endproperty
  a_hold_on: assert property (p_hold_on) else $error("amp0 dropped during conversion");
  property p_pulse_on;
    amp_pulse[0] |-> amp0_cfg.on || $past(amp0_cfg.on);
  endproperty
  a_pulse_on: assert property (p_pulse_on) else $error("amp0 pulse while off");
  property p_ps_event;
    amp1_cfg.on && amp1_cfg.trigSel == 2'h1 && power_stage_async_event[0] |-> ##[1:2] amp_pulse[1];
  endproperty
  a_ps_event: assert property (p_ps_event) else $error("amp1 missed stage 0 event");
  property p_div_sync;
    amp0_cfg.on && amp0_cfg.trigSel == TRIG_DIV8 |->
      ##[0:9] (amp_pulse[0] || !amp0_cfg.on || amp0_cfg.trigSel != TRIG_DIV8);
  endproperty
  a_div_sync: assert property (p_div_sync) else $error("amp0 no clock/8 pulse");
  c_conv0: cover property (conv_done[0]);
  c_pulse1: cover property (amp_pulse[1]);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind amp_ctrl amp_ctrl_properties chk_i (.clock(clock), .reset_n(reset_n),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .power_stage_async_event(power_stage_async_event), .amp0_cfg(amp0_cfg),
  .amp1_cfg(amp1_cfg), .amp_pulse(amp_pulse), .conv_clock_div8(conv_clock_div8),
  .conv_done(conv_done));
`default_nettype wire

// *** test/amp_ctrl_tb.sv ***
// Purpose: register and conversion tests of the amplifier block over AXI4-Lite
// Assumes: 100 ns clock, reset held 8 cycles
// Notes: conversion counts include the far model's register stage and the output flop
`timescale 1ns/10ps
`default_nettype none
module amp_ctrl_tb;
  import amp_ctrl_pkg::*;
  logic clock = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic awready, wready, bvalid, arready, rvalid, div8;
  logic [1:0] bresp, rresp, pulse, done, start, r, req = 0;
  logic [2:0] fire = 0, psEv;
  amp_cfg_s cfg0, cfg1;
  int num_errors = 0, tests_run = 0, cyc = 0, t0 = 0, d0 = 0, d1 = 0, p1 = 0, nLow, nHigh;
  always #50 clock = ~clock;
  // cycle and conversion tallies
  always @(posedge clock) begin
    cyc++;
    d0 += done[0];
    d1 += done[1];
    p1 += pulse[1];
  end
  amp_ctrl dut (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .power_stage_async_event(psEv), .start_conv(start),
    .sample_in(10'h2A5), .amp0_cfg(cfg0), .amp1_cfg(cfg1), .amp_pulse(pulse),
    .conv_clock_div8(div8), .conv_done(done));
  conv_side_model far (.clock(clock), .reset_n(reset_n), .fire(fire), .req(req),
    .psEvent(psEv), .startReq(start));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic awTaken, wTaken;
    awTaken = 1'b0;
    wTaken = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel is released at the edge where its own ready is seen high
    while (!(awTaken && wTaken)) begin
      @(posedge clock);
      if (!awTaken && awready === 1'b1) begin
        awvalid <= 1'b0;
        awTaken = 1'b1;
      end
      if (!wTaken && wready === 1'b1) begin
        wvalid <= 1'b0;
        wTaken = 1'b1;
      end
    end
    while (bvalid !== 1'b1) @(posedge clock);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a, v, r);
    chk(n, e, v);
  endtask
  // returns just after the divided clock has moved to lvl
  task automatic waitDiv(input logic lvl);
    logic prev;
    prev = lvl;
    while (!(prev !== lvl && div8 === lvl)) begin
      prev = div8;
      @(negedge clock);
    end
  endtask
  task automatic kick(input int ch);
    @(posedge clock);
    req[ch] <= 1'b1;
    // read the tally off the edge, where it is settled
    @(negedge clock);
    t0 = cyc;
    @(posedge clock);
    req[ch] <= 1'b0;
  endtask
  task automatic waitDone(input int ch, output int n);
    do @(negedge clock); while (done[ch] !== 1'b1 && cyc - t0 < 80);
    n = cyc - t0;
    chk("conv done", 32'h1, 32'(done[ch]));
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a hang costs a mismatch; the tests need well under 1000 cycles
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rdchk("amp0 reset", AMP0_OFFSET, 32'h0);
    rdchk("amp1 reset", AMP1_OFFSET, 32'h0);
    wr(AMP0_OFFSET, 32'hFF, r);
    rdchk("amp0 reserved", AMP0_OFFSET, 32'hF3);
    chk("amp0 cfg", 32'h3F, 32'(cfg0));
    wr(AMP0_OFFSET, 32'h0, r);
    repeat (2) @(negedge clock);
    chk("amp0 off", 32'h0, 32'(cfg0));
    wr(8'h10, 32'h1, r);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
    rd(8'h10, v, r);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    // 0x11 per step walks gain and trigger codes together
    for (int g = 0; g < 4; g++) begin
      wr(AMP1_OFFSET, 32'(g * 17), r);
      rdchk("amp1 fields", AMP1_OFFSET, 32'(g * 17));
      chk("amp1 cfg", 32'(g * 5), 32'(cfg1));
    end
    repeat (32) @(posedge clock);
    wr(AMP0_OFFSET, 32'h80, r);
    waitDiv(1'b0);
    kick(0);
    waitDone(0, nLow);
    waitDiv(1'b1);
    kick(0);
    waitDone(0, nHigh);
    chk("high phase extra cycle", 32'(nLow + 1), 32'(nHigh));
    // three extra edges: model register, request sampling and output flop
    chk("low phase cycles", 32'(CONV_CYC_LOW) + 32'h3, 32'(nLow));
    rdchk("result", RESULT_OFFSET, 32'h2A5);
    kick(0);
    wr(AMP0_OFFSET, 32'h0, r);
    chk("on held", 32'h1, 32'(cfg0.on));
    waitDone(0, nLow);
    @(negedge clock);
    chk("on released", 32'h0, 32'(cfg0.on));
    wr(AMP1_OFFSET, 32'h81, r);
    kick(1);
    repeat (20) @(negedge clock);
    chk("no trigger no conv", 32'h0, 32'(d1));
    @(posedge clock);
    fire <= 3'h1;
    @(posedge clock);
    fire <= 3'h0;
    waitDone(1, nHigh);
    chk("amp1 pulses", 32'h1, 32'(p1));
    wr(AMP1_OFFSET, 32'h0, r);
    chk("conv count", 32'h3, 32'(d0));
    tally_and_finish();
  end
endmodule
`default_nettype wire
